// ===== hdl/jtp_pkg.sv
// constants for the test-access and security port
// assumes nothing of its surroundings
package jtp_pkg;
	localparam int IR_W = 4;
	localparam logic [3:0] CMD_BYPASS = 4'hF;
	localparam logic [3:0] CMD_ENABLE = 4'h1;
	localparam logic [3:0] CMD_ENABLE6 = 4'h2;
	localparam logic [3:0] CMD_ERASE = 4'h3;
	localparam logic [3:0] CMD_PROGRAM = 4'h4;
	localparam logic [3:0] CMD_READ = 4'h5;
	localparam logic [3:0] CMD_SECURE = 4'h6;
	localparam logic [3:0] CMD_DEBUG = 4'h7;
	localparam logic [3:0] IR_CAPTURE = 4'h1;
	localparam int DR_W = 16;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;
	localparam int PROG_CYCLES = 8;
	localparam int ERASE_CYCLES = 32;
	typedef enum logic [3:0] {
		ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h2,
		ST_CAP_DR = 4'h3, ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5,
		ST_PA_DR = 4'h6, ST_EX2_DR = 4'h7, ST_UPD_DR = 4'h8,
		ST_SEL_IR = 4'h9, ST_CAP_IR = 4'hA, ST_SH_IR = 4'hB,
		ST_EX1_IR = 4'hC, ST_PA_IR = 4'hD, ST_EX2_IR = 4'hE,
		ST_UPD_IR = 4'hF
	} jtp_tap_t;
endpackage

// ===== hdl/jtp_port.sv
// test-access port with in-package die chain, status flags and lock
// assumes tck/tms/tdi and debug pin are asynchronous pins
// Behaviour
// RQ1 - the four test pins always serve the test port, never general io
// RQ2 - programming is driven wholly from outside, no core firmware needed
// RQ3 - outside equipment holds device reset during programming
// RQ4 - ready flag high when location programmed, low while busy
// RQ5 - error flag low on programming error, high otherwise
// RQ6 - ready and error flags enabled together as one pair only
// RQ7 - flags available only when port c bits 3 and 4 dedicated
// RQ8 - flags meaningful only during programming, idle during core debug
// RQ9 - flags open-drain by default, push-pull selectable
// RQ10 - chained devices pass serial output to next serial input
// RQ11 - only one chained device operates, others held in bypass
// RQ12 - debug pin as output signals an internal event
// RQ13 - debug pin as input starts an internal debug event
// RQ14 - secured device accepts only full-chip erase
// RQ15 - secured device refuses memory access and core debug
// RQ16 - only full-chip erase clears security, leaving device blank
// RQ17 - core keeps read access to memory over 8-bit bus always
// RQ18 - erased memory and logic bits read as one
// RQ19 - serial input feeds memory die, then processor die, then output
// RQ20 - pins start as inputs, output enabled by enabling command
// RQ21 - tap logic independent of device reset
// RQ22 - equipment waits for ready then checks error per location
// RQ23 - stored security bit gates commands before decode
`timescale 1ns/1ps
`default_nettype none
module jtp_port
	import jtp_pkg::*;
#(
	parameter int ADDR_W = 6
) (
	input  wire logic              ref_clk_in,
	input  wire logic              rst_n_in,
	input  wire logic              tck_in,
	input  wire logic              tms_in,
	input  wire logic              tdi_in,
	input  wire logic              port_c_bit3_dedicated_in,
	input  wire logic              port_c_bit4_dedicated_in,
	input  wire logic              flag_push_pull_in,
	input  wire logic              debug_pin_is_output_in,
	input  wire logic              debug_pin_in,
	input  wire logic              debug_event_in,
	input  wire logic              prog_fail_in,
	input  wire logic [ADDR_W-1:0] core_addr_in,
	output logic                   tdo_out,
	output logic                   tdo_oe_out,
	output logic                   prog_ready_flag_out,
	output logic                   prog_ready_flag_oe_out,
	output logic                   prog_error_flag_out,
	output logic                   prog_error_flag_oe_out,
	output logic                   debug_pin_out,
	output logic                   debug_pin_oe_out,
	output logic                   core_halt_out,
	output logic [7:0]             core_data_out,
	output logic                   secured_out
);
	import jtp_pkg::*;

	localparam int DEPTH = 1 << ADDR_W;

	// pins at rest: debug high, tdi low, tms high, tck low
	localparam logic [3:0] PIN_REST = 4'hA;

	// two-flop synchronisers; first stage read only by second
	logic [3:0] s1 = PIN_REST;
	logic [3:0] s2 = PIN_REST;
	logic       tck_d = 1'b0;
	always_ff @(posedge ref_clk_in) begin
		s1 <= {debug_pin_in, tdi_in, tms_in, tck_in};
		s2 <= s1;
		tck_d <= s2[0];
	end
	wire tck_rise = s2[0] & ~tck_d;
	wire tck_fall = ~s2[0] & tck_d;

	// tap state: runs from tms alone, not from device reset  RQ21
	jtp_tap_t tap = ST_RESET;
	jtp_tap_t next_tap;
	always_comb begin
		case (tap)
		ST_RESET:  next_tap = s2[1] ? ST_RESET : ST_IDLE;
		ST_IDLE:   next_tap = s2[1] ? ST_SEL_DR : ST_IDLE;
		ST_SEL_DR: next_tap = s2[1] ? ST_SEL_IR : ST_CAP_DR;
		ST_CAP_DR: next_tap = s2[1] ? ST_EX1_DR : ST_SH_DR;
		ST_SH_DR:  next_tap = s2[1] ? ST_EX1_DR : ST_SH_DR;
		ST_EX1_DR: next_tap = s2[1] ? ST_UPD_DR : ST_PA_DR;
		ST_PA_DR:  next_tap = s2[1] ? ST_EX2_DR : ST_PA_DR;
		ST_EX2_DR: next_tap = s2[1] ? ST_UPD_DR : ST_SH_DR;
		ST_UPD_DR: next_tap = s2[1] ? ST_SEL_DR : ST_IDLE;
		ST_SEL_IR: next_tap = s2[1] ? ST_RESET : ST_CAP_IR;
		ST_CAP_IR: next_tap = s2[1] ? ST_EX1_IR : ST_SH_IR;
		ST_SH_IR:  next_tap = s2[1] ? ST_EX1_IR : ST_SH_IR;
		ST_EX1_IR: next_tap = s2[1] ? ST_UPD_IR : ST_PA_IR;
		ST_PA_IR:  next_tap = s2[1] ? ST_EX2_IR : ST_PA_IR;
		ST_EX2_IR: next_tap = s2[1] ? ST_UPD_IR : ST_SH_IR;
		ST_UPD_IR: next_tap = s2[1] ? ST_SEL_DR : ST_IDLE;
		default:   next_tap = ST_RESET;
		endcase
	end

	// memory die first, processor die second in the serial path  RQ19
	// power-up values: device reset must never touch the test port
	logic [IR_W-1:0] ir_sh = '0;
	logic [IR_W-1:0] ir = CMD_BYPASS;
	logic [IR_W-1:0] next_ir_sh, next_ir;
	logic [DR_W-1:0] dr_sh = '0;
	logic [DR_W-1:0] next_dr_sh;
	logic            mem_byp = 1'b0;
	logic            core_byp = 1'b0;
	logic            next_mem_byp, next_core_byp;
	logic            tdo_q = 1'b0;
	logic            next_tdo_q;
	logic            tdo_en = 1'b0;
	logic            next_tdo_en;
	logic            flags_en = 1'b0;
	logic            next_flags_en;
	// lock is non-volatile: delivered clear, survives device reset
	logic            secured = 1'b0;
	logic            next_secured;
	logic            debug_on = 1'b0;
	logic            next_debug_on;
	logic [ADDR_W-1:0] addr = '0;
	logic [ADDR_W-1:0] next_addr;
	// delivered erased  RQ18
	logic [DR_W-1:0]   mem [DEPTH] = '{default: ERASED_WORD};
	logic            do_prog, do_erase;
	logic [DR_W-1:0] rd_word;

	wire in_ir = (tap == ST_SH_IR);
	wire in_dr = (tap == ST_SH_DR);
	// lock checked before decode: only erase survives  RQ23 RQ14
	wire [IR_W-1:0] cmd = (secured && ir != CMD_ERASE && ir != CMD_BYPASS)
	                      ? CMD_BYPASS : ir;
	wire mem_cmd = (cmd == CMD_PROGRAM) || (cmd == CMD_READ);
	// data register owner: memory die for its commands, core for debug
	wire mem_dr = mem_cmd || (cmd == CMD_ERASE) || (cmd == CMD_SECURE);
	wire core_dr = (cmd == CMD_DEBUG);
	assign rd_word = mem[addr];

	always_comb begin
		next_ir_sh = ir_sh;
		next_ir = ir;
		next_dr_sh = dr_sh;
		next_mem_byp = mem_byp;
		next_core_byp = core_byp;
		next_tdo_q = tdo_q;
		next_tdo_en = tdo_en;
		next_flags_en = flags_en;
		next_secured = secured;
		next_debug_on = debug_on;
		next_addr = addr;
		do_prog = 1'b0;
		do_erase = 1'b0;
		if (tck_rise) begin
			case (tap)
			ST_RESET: next_ir = CMD_BYPASS;
			ST_CAP_IR: next_ir_sh = IR_CAPTURE;
			ST_SH_IR: next_ir_sh = {s2[2], ir_sh[IR_W-1:1]};
			ST_UPD_IR: next_ir = ir_sh;
			ST_CAP_DR: begin
				next_dr_sh = mem_cmd ? rd_word : '0; // RQ15
				next_mem_byp = 1'b0;
				next_core_byp = 1'b0;
			end
			ST_SH_DR: begin
				// a bypassed die is one flop; only one die active  RQ11
				if (mem_dr) begin
					next_dr_sh = {s2[2], dr_sh[DR_W-1:1]};
					next_core_byp = dr_sh[0];
				end else if (core_dr) begin
					next_mem_byp = s2[2];
					next_dr_sh = {mem_byp, dr_sh[DR_W-1:1]};
				end else begin
					next_mem_byp = s2[2];
					next_core_byp = mem_byp;
				end
			end
			ST_UPD_DR: begin
				case (cmd)
				CMD_PROGRAM: begin
					do_prog = 1'b1;
					next_addr = addr + 1'b1;
				end
				CMD_READ: next_addr = addr + 1'b1;
				CMD_ERASE: begin
					do_erase = 1'b1; // RQ16
					next_secured = 1'b0;
					next_addr = '0;
				end
				CMD_SECURE: next_secured = 1'b1;
				default: ;
				endcase
			end
			default: ;
			endcase
			// enabling command turns on output and optionally flags  RQ20
			if (tap == ST_UPD_IR && (ir_sh == CMD_ENABLE ||
			    ir_sh == CMD_ENABLE6) && !secured) begin
				next_tdo_en = 1'b1;
				next_flags_en = (ir_sh == CMD_ENABLE6);
			end
			if (tap == ST_UPD_IR)
				next_debug_on = (ir_sh == CMD_DEBUG) && !secured; // RQ15
		end
		// serial output changes on falling edge, processor die last  RQ10
		if (tck_fall && in_ir)
			next_tdo_q = ir_sh[0];
		else if (tck_fall && in_dr)
			next_tdo_q = core_dr ? dr_sh[0] : core_byp;
	end

	// programming engine
	logic [5:0]        busy_cnt = '0;
	logic [5:0]        next_busy_cnt;
	logic              prog_err = 1'b0;
	logic              next_prog_err;
	logic              erasing = 1'b0;
	logic              next_erasing;
	logic [ADDR_W-1:0] wr_addr = '0;
	logic [ADDR_W-1:0] next_wr_addr;
	logic [DR_W-1:0]   wr_data = '0;
	logic [DR_W-1:0]   next_wr_data;
	always_comb begin
		next_busy_cnt = busy_cnt;
		next_prog_err = prog_err;
		next_erasing = erasing;
		next_wr_addr = wr_addr;
		next_wr_data = wr_data;
		if (busy_cnt != '0)
			next_busy_cnt = busy_cnt - 1'b1;
		if (do_prog) begin
			next_busy_cnt = 6'(PROG_CYCLES);
			next_wr_addr = addr;
			next_wr_data = dr_sh & mem[addr]; // bits only clear
			next_prog_err = 1'b0;
		end
		if (do_erase) begin
			next_busy_cnt = 6'(ERASE_CYCLES);
			next_erasing = 1'b1;
			next_prog_err = 1'b0;
		end
		if (busy_cnt == 6'h01) begin
			next_erasing = 1'b0;
			if (prog_fail_in)
				next_prog_err = 1'b1; // RQ5
		end
	end

	always_ff @(posedge ref_clk_in) begin
		// device reset leaves the tap alone  RQ21
		if (tck_rise)
			tap <= next_tap;
		ir_sh <= next_ir_sh;
		ir <= next_ir;
		dr_sh <= next_dr_sh;
		mem_byp <= next_mem_byp;
		core_byp <= next_core_byp;
		tdo_q <= next_tdo_q;
		secured <= next_secured;
		addr <= next_addr;
		debug_on <= next_debug_on;
		busy_cnt <= next_busy_cnt;
		prog_err <= next_prog_err;
		erasing <= next_erasing;
		wr_addr <= next_wr_addr;
		wr_data <= next_wr_data;
		tdo_en <= next_tdo_en;
		flags_en <= next_flags_en;
	end

	// memory array; erased state all ones  RQ18
	always_ff @(posedge ref_clk_in) begin
		if (erasing && busy_cnt == 6'h01)
			for (int i = 0; i < DEPTH; i++)
				mem[i] <= ERASED_WORD;
		else if (busy_cnt == 6'h01 && !prog_fail_in)
			mem[wr_addr] <= wr_data;
	end

	// pins: flags paired, port c dedicated, only during programming
	logic flag_on, ready_v, error_v;
	always_comb begin
		flag_on = flags_en && port_c_bit3_dedicated_in
		          && port_c_bit4_dedicated_in && !debug_on; // RQ6 RQ7 RQ8
		ready_v = (busy_cnt == '0); // RQ4
		error_v = !prog_err; // RQ5
	end

	always_ff @(posedge ref_clk_in) begin
		tdo_out <= tdo_q;
		tdo_oe_out <= tdo_en; // RQ1 RQ20
		prog_ready_flag_out <= flag_push_pull_in ? ready_v : 1'b0;
		// open-drain drives only low; push-pull drives both  RQ9
		prog_ready_flag_oe_out <= flag_on && (flag_push_pull_in || !ready_v);
		prog_error_flag_out <= flag_push_pull_in ? error_v : 1'b0;
		prog_error_flag_oe_out <= flag_on && (flag_push_pull_in || !error_v);
		// debug pin out or in  RQ12 RQ13
		debug_pin_oe_out <= debug_pin_is_output_in;
		// device reset clears only the core-side debug outputs
		if (!rst_n_in) begin
			debug_pin_out <= 1'b0;
			core_halt_out <= 1'b0;
		end else begin
			debug_pin_out <= debug_on && debug_event_in;
			core_halt_out <= debug_on && !debug_pin_is_output_in && !s2[3];
		end
		// core reads regardless of lock  RQ17
		core_data_out <= mem[core_addr_in][7:0];
		secured_out <= secured;
	end
endmodule
`default_nettype wire

// ===== dv/jtp_port_props.sv
// assertions on the pins of the test port
// assumes binding onto jtp_port, one clock domain
`timescale 1ns/1ps
`default_nettype none
module jtp_port_props (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic port_c_bit3_dedicated_in,
	input wire logic port_c_bit4_dedicated_in,
	input wire logic flag_push_pull_in,
	input wire logic debug_pin_is_output_in,
	input wire logic debug_pin_in,
	input wire logic debug_event_in,
	input wire logic prog_ready_flag_out,
	input wire logic prog_ready_flag_oe_out,
	input wire logic prog_error_flag_out,
	input wire logic prog_error_flag_oe_out,
	input wire logic debug_pin_out,
	input wire logic debug_pin_oe_out,
	input wire logic core_halt_out,
	input wire logic secured_out
);
	wire logic pins = port_c_bit3_dedicated_in & port_c_bit4_dedicated_in;
	wire logic busy = prog_ready_flag_oe_out & ~prog_ready_flag_out;
	wire logic pp = flag_push_pull_in;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	a_ready_pins: assert property ((!pins)[*3] |-> !prog_ready_flag_oe_out)
		else $error("ready flag driven without pin select");
	a_error_pins: assert property ((!pins)[*3] |-> !prog_error_flag_oe_out)
		else $error("error flag driven without pin select");
	a_open_drain: assert property ((!pp)[*2] |->
		!(prog_ready_flag_oe_out && prog_ready_flag_out) &&
		!(prog_error_flag_oe_out && prog_error_flag_out))
		else $error("open-drain flag driven high");
	a_flags_paired: assert property ((pp && pins)[*3] |->
		prog_ready_flag_oe_out == prog_error_flag_oe_out)
		else $error("flags not driven as a pair");
	a_busy_window: assert property ($rose(busy) |-> busy[*7])
		else $error("busy phase too short");
	a_halt_pin: assert property ($rose(core_halt_out) |->
		!$past(debug_pin_in, 3) && !$past(debug_pin_is_output_in))
		else $error("halt without debug pin request");
	a_event_pin: assert property ((debug_pin_oe_out && debug_pin_out) |->
		$past(debug_event_in) && $past(debug_pin_is_output_in))
		else $error("debug pin driven without internal event");
	a_pin_input: assert property ((!debug_pin_is_output_in)[*3] |->
		!debug_pin_oe_out)
		else $error("debug pin driven in input mode");
	cover property ($rose(busy));
	cover property ($rose(secured_out));
	cover property ($rose(core_halt_out));
endmodule
`default_nettype wire

// ===== dv/jtp_host.sv
// model of the external programming equipment
// assumes the device samples tck with its own clock
`timescale 1ns/1ps
`default_nettype none
module jtp_host (
	input  wire logic tdo_in,
	output logic tck_out,
	output logic tms_out,
	output logic tdi_out,
	output logic rst_n_out
);
	initial begin
		tck_out = 1'b0;
		tms_out = 1'b1;
		tdi_out = 1'b0;
		rst_n_out = 1'b1;
	end
	logic        tdo_bit = 1'b0;
	logic [15:0] got = '0;
	// one tck period, tck rests low between frames
	// tdo sampled just before the fall, where it has long settled
	task automatic bit_out(input logic m, input logic d);
		tms_out = m;
		tdi_out = d;
		#80 tck_out = 1'b1;
		#80 tdo_bit = tdo_in;
		tck_out = 1'b0;
	endtask
	task automatic tap_reset();
		repeat (5) bit_out(1'b1, ~tdi_out);
		bit_out(1'b0, ~tdi_out);
	endtask
	// lsb first; returns right after the update edge
	task automatic shift(input logic ir, input logic [15:0] v);
		int n;
		n = ir ? 4 : 16;
		bit_out(1'b1, ~tdi_out);
		if (ir) bit_out(1'b1, ~tdi_out);
		bit_out(1'b0, ~tdi_out);
		bit_out(1'b0, ~tdi_out);
		for (int i = 0; i < n; i++) begin
			bit_out(i == n - 1, v[i]);
			got[i] = tdo_bit;
		end
		bit_out(1'b1, ~tdi_out);
		bit_out(1'b0, ~tdi_out);
	endtask
	// open-drain reset onto the device
	task automatic hold_reset(input logic on);
		rst_n_out = ~on;
	endtask
endmodule
`default_nettype wire

// ===== dv/tb_jtp_port.sv
// self-checking bench for the test port
// assumes jtp_host drives the link pins
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin \
	miscompares++; $display("MISMATCH %s exp %h got %h", nm, e, a); end end
module tb_jtp_port;
	import jtp_pkg::*;
	logic ref_clk_in = 1'b0, tb_rst_n = 1'b0, flag_push_pull_in = 1'b0;
	logic port_c_bit3_dedicated_in = 1'b0, port_c_bit4_dedicated_in = 1'b0;
	logic debug_pin_is_output_in = 1'b0, debug_event_in = 1'b0;
	logic prog_fail_in = 1'b0, dbg_drv = 1'b1;
	logic [5:0] core_addr_in = 6'h00;
	logic tdo_out, tdo_oe_out, prog_ready_flag_out, prog_ready_flag_oe_out;
	logic prog_error_flag_out, prog_error_flag_oe_out, debug_pin_out;
	logic debug_pin_oe_out, core_halt_out, secured_out;
	logic [7:0] core_data_out;
	wire logic tck_in, tms_in, tdi_in, host_rst_n, rst_n_in, debug_pin_in;
	wire logic rdy_w, err_w;
	int miscompares = 0, n_compared = 0;
	assign rst_n_in = tb_rst_n & host_rst_n;
	assign rdy_w = prog_ready_flag_oe_out ? prog_ready_flag_out : 1'b1;
	assign err_w = prog_error_flag_oe_out ? prog_error_flag_out : 1'b1;
	assign debug_pin_in = debug_pin_oe_out ? debug_pin_out : dbg_drv;
	always #10 ref_clk_in = ~ref_clk_in;
	jtp_port dut_u (.*);
	jtp_host host_u (.tdo_in(tdo_out), .tck_out(tck_in), .tms_out(tms_in),
		.tdi_out(tdi_in), .rst_n_out(host_rst_n));
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask
	task automatic wait_rdy(input logic lvl, input int lim, input string nm);
		int i = 0;
		while (rdy_w !== lvl && i < lim) begin
			tick(1);
			i++;
		end
		`CHK(nm, lvl, rdy_w)
	endtask
	task automatic cmd(input logic [3:0] op, input logic [15:0] d);
		host_u.shift(1'b1, {12'h000, op});
		host_u.shift(1'b0, d);
	endtask
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		int lo = 0;
		tick(8);
		tb_rst_n = 1'b1;
		tick(2);
		`CHK("tdo_oe", 1'b0, tdo_oe_out)
		host_u.tap_reset();
		host_u.shift(1'b1, {12'h000, CMD_ENABLE6});
		`CHK("ir_cap", IR_CAPTURE, host_u.got[3:0])
		tick(6);
		`CHK("tdo_oe", 1'b1, tdo_oe_out)
		host_u.shift(1'b0, 16'hA5C3);
		`CHK("bypass", 16'h970C, host_u.got)
		`CHK("rdy_oe", 1'b0, prog_ready_flag_oe_out)
		port_c_bit3_dedicated_in = 1'b1;
		port_c_bit4_dedicated_in = 1'b1;
		host_u.hold_reset(1'b1);
		cmd(CMD_PROGRAM, 16'h1234);
		wait_rdy(1'b0, 8, "busy");
		wait_rdy(1'b1, 20, "ready");
		`CHK("err", 1'b1, err_w)
		prog_fail_in = 1'b1;
		host_u.shift(1'b0, 16'h5678);
		wait_rdy(1'b0, 8, "busy2");
		wait_rdy(1'b1, 20, "ready2");
		`CHK("err", 1'b0, err_w)
		prog_fail_in = 1'b0;
		host_u.hold_reset(1'b0);
		flag_push_pull_in = 1'b1;
		tick(6);
		`CHK("rdy_pp", 1'b1, rdy_w)
		flag_push_pull_in = 1'b0;
		core_addr_in = 6'h3F;
		tick(4);
		`CHK("core", 8'hFF, core_data_out)
		cmd(CMD_READ, 16'h0000);
		`CHK("read", 16'hFFFE, host_u.got)
		cmd(CMD_SECURE, 16'h0000);
		tick(6);
		`CHK("secured", 1'b1, secured_out)
		tb_rst_n = 1'b0;
		tick(8);
		tb_rst_n = 1'b1;
		tick(2);
		`CHK("secured", 1'b1, secured_out)
		`CHK("core", 8'hFF, core_data_out)
		cmd(CMD_PROGRAM, 16'h00F0);
		`CHK("locked", 16'h03C0, host_u.got)
		repeat (40) begin
			tick(1);
			lo += (rdy_w === 1'b0);
		end
		`CHK("refused", 0, lo)
		cmd(CMD_ERASE, 16'h0000);
		tick(ERASE_CYCLES + 20);
		`CHK("secured", 1'b0, secured_out)
		core_addr_in = 6'h00;
		tick(4);
		`CHK("core", 8'hFF, core_data_out)
		host_u.shift(1'b1, {12'h000, CMD_DEBUG});
		tick(6);
		dbg_drv = 1'b0;
		tick(8);
		`CHK("halt", 1'b1, core_halt_out)
		dbg_drv = 1'b1;
		tick(8);
		`CHK("halt", 1'b0, core_halt_out)
		debug_pin_is_output_in = 1'b1;
		dbg_drv = 1'b0;
		debug_event_in = 1'b1;
		tick(8);
		`CHK("dbg_pin", 1'b1, debug_pin_in)
		`CHK("dbg_oe", 1'b1, debug_pin_oe_out)
		report_and_stop();
	end
	initial begin
		#500000;
		miscompares++;
		report_and_stop();
	end
endmodule
bind jtp_port jtp_port_props props_u (.*);
`default_nettype wire
